// File: design/float_trap_policy.v
// Result, condition code and exception policy stage of the floating-point unit
`timescale 1ns/1ps
`default_nettype none
`include "fp_policy_defines.vh"
// Operation
// - Trap keeps destination register unchanged
// - Trap keeps condition codes unchanged
// - Trap keeps accrued exceptions unchanged
// - IEEE trap sets exactly one current bit
// - NaN conversion copies top bits, forces quiet
// - Conversion: quiet silent, signaling raises invalid
// - Signaling compare: any NaN invalid, unordered
// - Quiet compare: unordered, invalid only signaling
// - Invalid without NaN returns default quiet NaN
// - One operand NaN: quiet passes, signaling quieted
// - Two quiet NaNs return second operand
// - Two signaling NaNs return quieted second
// - One signaling NaN returned quieted, invalid
// - One quiet NaN, no signaling: return it
// - Trapped underflow: tininess before rounding
// - Untrapped underflow needs tiny and inexact
// - Overflow judged on rounded result
// - Tiny inexact untrapped: inexact trap or flags
// - Float to int invalid on range, NaN
// - Untrapped invalid conversion saturates by sign
// - Nonstandard bit reads zero when standard
// - Flushed subnormal operands raise inexact
// - Flushed subnormal results raise underflow, inexact
module float_trap_policy #(
    parameter FLUSH_SUPPORT = 0
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_valid,
    input wire [3:0] i_op,
    input wire [1:0] i_src_fmt,
    input wire [1:0] i_dst_fmt,
    input wire i_two_nan_ops,
    input wire [63:0] i_src1,
    input wire [63:0] i_src2,
    input wire [63:0] i_core_result,
    input wire [4:0] i_core_exc,
    input wire [1:0] i_core_fcc,
    input wire i_tiny,
    input wire i_inexact,
    input wire i_rounded_overflow,
    input wire i_result_sub,
    input wire i_int_out_of_range,
    input wire [4:0] i_trap_mask,
    input wire i_ns_wr,
    input wire i_ns_wdata,
    output reg [63:0] o_dest,
    output reg o_dest_we,
    output reg [1:0] o_fcc,
    output reg [4:0] o_cexc,
    output reg [4:0] o_aexc,
    output reg o_float_trap,
    output reg [2:0] o_trap_type,
    output reg o_nonstandard_mode_bit
);
    wire a_nan;
    wire a_snan;
    wire a_sub;
    wire a_inf;
    wire a_sign;
    wire b_nan;
    wire b_snan;
    wire b_sub;
    wire b_inf;
    wire b_sign;
    wire [63:0] conv_nan;
    reg ns_mode;
    reg [63:0] next_result;
    reg [4:0] next_exc;
    reg [1:0] next_fcc;
    reg next_write_fcc;
    reg [4:0] trap_bits;
    reg [4:0] one_hot;
    reg uf_event;
    reg nx_event;
    wire underflow_trap_mask;
    wire inexact_trap_mask;
    wire flush;

    assign underflow_trap_mask = i_trap_mask[`EXC_UF];
    assign inexact_trap_mask = i_trap_mask[`EXC_NX];
    assign flush = ns_mode && (FLUSH_SUPPORT != 0);

    fp_nan_classify u_class_a (
        .i_val(i_src1),
        .i_fmt(i_src_fmt),
        .o_is_nan(a_nan),
        .o_is_snan(a_snan),
        .o_is_sub(a_sub),
        .o_is_inf(a_inf),
        .o_sign(a_sign)
    );

    fp_nan_classify u_class_b (
        .i_val(i_src2),
        .i_fmt(i_src_fmt),
        .o_is_nan(b_nan),
        .o_is_snan(b_snan),
        .o_is_sub(b_sub),
        .o_is_inf(b_inf),
        .o_sign(b_sign)
    );

    // Single-operand ops take their source from the second operand
    fp_nan_convert u_conv (
        .i_val(i_src2),
        .i_src_fmt(i_src_fmt),
        .i_dst_fmt(i_dst_fmt),
        .o_val(conv_nan)
    );

    // Quiet the second or first operand in its own format
    function [63:0] quieten;
        input [63:0] v;
        input [1:0] fmt;
        begin
            if (fmt == `FMT_D) begin
                quieten = {v[63:52], 1'b1, v[50:0]};
            end else begin
                quieten = {32'h0, v[31:23], 1'b1, v[21:0]};
            end
        end
    endfunction

    // Result, exception and condition code selection
    always @* begin
        next_result = i_core_result;
        next_exc = i_core_exc;
        next_fcc = i_core_fcc;
        next_write_fcc = 1'b0;
        uf_event = 1'b0;
        nx_event = 1'b0;
        case (i_op)
            `OP_CONVERT: begin
                if (b_nan) begin
                    next_result = conv_nan;
                    next_exc = {b_snan, 4'h0};
                end
            end
            `OP_SCMP: begin
                next_write_fcc = 1'b1;
                if (a_nan || b_nan) begin
                    next_fcc = `FCC_UNORD;
                    next_exc = 5'h10;
                end
            end
            `OP_QCMP: begin
                next_write_fcc = 1'b1;
                if (a_nan || b_nan) begin
                    next_fcc = `FCC_UNORD;
                    next_exc = {a_snan || b_snan, 4'h0};
                end
            end
            `OP_TOINT: begin
                if (b_nan || b_inf || i_int_out_of_range) begin
                    next_exc = 5'h10;
                    next_result = b_sign ? {32'h0, `INT_NEG_SAT} :
                        {32'h0, `INT_POS_SAT};
                end
            end
            `OP_ARITH1: begin
                if (b_nan) begin
                    next_result = b_snan ? quieten(i_src2, i_src_fmt) : i_src2;
                    next_exc = {b_snan, 4'h0};
                end else if (i_core_exc[`EXC_NV]) begin
                    next_result = (i_dst_fmt == `FMT_D) ? 64'h7FFFFFFFFFFFFFFF :
                        64'h000000007FFFFFFF;
                end
            end
            `OP_ARITH2: begin
                if (a_snan && !b_snan) begin
                    next_result = quieten(i_src1, i_src_fmt);
                    next_exc = 5'h10;
                end else if (b_snan) begin
                    next_result = quieten(i_src2, i_src_fmt);
                    next_exc = 5'h10;
                end else if (b_nan) begin
                    next_result = i_src2;
                    next_exc = 5'h00;
                end else if (a_nan) begin
                    next_result = i_src1;
                    next_exc = 5'h00;
                end else if (i_core_exc[`EXC_NV]) begin
                    next_result = (i_dst_fmt == `FMT_D) ? 64'h7FFFFFFFFFFFFFFF :
                        64'h000000007FFFFFFF;
                end else begin
                    // Underflow and flush policy applies only to numeric results
                    if (flush && (a_sub || b_sub) && (i_core_exc == 5'h00)) begin
                        nx_event = 1'b1;
                    end
                    if (flush && i_result_sub) begin
                        uf_event = 1'b1;
                        nx_event = 1'b1;
                        next_result = (i_dst_fmt == `FMT_D) ?
                            {i_core_result[63], 63'h0} :
                            {32'h0, i_core_result[31], 31'h0};
                    end
                    if (i_tiny && underflow_trap_mask) begin
                        uf_event = 1'b1;
                    end
                    if (i_tiny && i_inexact) begin
                        uf_event = 1'b1;
                        nx_event = 1'b1;
                    end
                    next_exc[`EXC_OF] = i_rounded_overflow;
                    next_exc[`EXC_UF] = uf_event;
                    next_exc[`EXC_NX] = i_core_exc[`EXC_NX] || nx_event;
                end
            end
            default: begin
                next_result = i_core_result;
            end
        endcase
    end

    // Highest priority trapping exception becomes the single current bit
    always @* begin
        trap_bits = next_exc & i_trap_mask;
        one_hot = 5'h00;
        if (trap_bits[`EXC_NV]) begin
            one_hot[`EXC_NV] = 1'b1;
        end else if (trap_bits[`EXC_OF]) begin
            one_hot[`EXC_OF] = 1'b1;
        end else if (trap_bits[`EXC_UF]) begin
            one_hot[`EXC_UF] = 1'b1;
        end else if (trap_bits[`EXC_DZ]) begin
            one_hot[`EXC_DZ] = 1'b1;
        end else if (trap_bits[`EXC_NX]) begin
            one_hot[`EXC_NX] = 1'b1;
        end
        // Untrapped underflow with inexact trap on: only inexact traps
        if (!underflow_trap_mask && trap_bits[`EXC_NX] && next_exc[`EXC_UF] &&
            trap_bits[4:1] == 4'h0) begin
            one_hot = 5'h01;
        end
    end

    // Architectural state update; a trap blocks every write but one cexc bit and the trap type
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dest <= `RST_REG;
            o_dest_we <= 1'b0;
            o_fcc <= `RST_FCC;
            o_cexc <= `RST_EXC;
            o_aexc <= `RST_EXC;
            o_float_trap <= 1'b0;
            o_trap_type <= `TT_NONE;
        end else begin
            o_dest_we <= 1'b0;
            o_float_trap <= 1'b0;
            if (i_valid) begin
                if (trap_bits != 5'h00) begin
                    o_float_trap <= 1'b1;
                    o_trap_type <= `TT_IEEE;
                    o_cexc <= one_hot;
                    // Destination, fcc and aexc held as they were
                    o_dest <= o_dest;
                    o_fcc <= o_fcc;
                    o_aexc <= o_aexc;
                end else begin
                    o_trap_type <= `TT_NONE;
                    o_cexc <= next_exc;
                    o_aexc <= o_aexc | next_exc;
                    if (next_write_fcc) begin
                        o_fcc <= next_fcc;
                    end else begin
                        o_dest <= next_result;
                        o_dest_we <= 1'b1;
                    end
                end
            end
        end
    end

    // Mode bit sticks at zero unless flushing hardware is present
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ns_mode <= 1'b0;
            o_nonstandard_mode_bit <= 1'b0;
        end else if (i_ns_wr) begin
            ns_mode <= (FLUSH_SUPPORT != 0) ? i_ns_wdata : 1'b0;
            o_nonstandard_mode_bit <= (FLUSH_SUPPORT != 0) ? i_ns_wdata : 1'b0;
        end
    end
endmodule // float_trap_policy
`default_nettype wire

// File: design/fp_policy_defines.vh
// Constants for the floating-point result and exception policy block
`ifndef FP_POLICY_DEFINES_VH
`define FP_POLICY_DEFINES_VH
// Operation codes
`define OP_NONE 4'h0
`define OP_ARITH1 4'h1
`define OP_ARITH2 4'h2
`define OP_CONVERT 4'h3
`define OP_QCMP 4'h4
`define OP_SCMP 4'h5
`define OP_TOINT 4'h6
// Formats
`define FMT_S 2'h0
`define FMT_D 2'h1
// Exception vector bit positions {nv,of,uf,dz,nx}
`define EXC_NV 4
`define EXC_OF 3
`define EXC_UF 2
`define EXC_DZ 1
`define EXC_NX 0
// Condition code for unordered
`define FCC_UNORD 2'h3
// Integer saturation values
`define INT_POS_SAT 32'h7FFFFFFF
`define INT_NEG_SAT 32'h80000000
// Reset values
`define RST_REG 64'h0000000000000000
`define RST_FCC 2'h0
`define RST_EXC 5'h00
// Trap type for IEEE exceptions (used as status only)
`define TT_NONE 3'h0
`define TT_IEEE 3'h1
`endif

// File: design/fp_nan_classify.v
// NaN and subnormal classification of one operand in single or double format
`timescale 1ns/1ps
`default_nettype none
`include "fp_policy_defines.vh"
module fp_nan_classify (
    input wire [63:0] i_val,
    input wire [1:0] i_fmt,
    output reg o_is_nan,
    output reg o_is_snan,
    output reg o_is_sub,
    output reg o_is_inf,
    output reg o_sign
);
    // Single sits in the low 32 bits
    always @* begin
        if (i_fmt == `FMT_D) begin
            o_sign = i_val[63];
            o_is_nan = (i_val[62:52] == 11'h7FF) && (i_val[51:0] != 52'h0);
            o_is_snan = o_is_nan && !i_val[51];
            o_is_inf = (i_val[62:52] == 11'h7FF) && (i_val[51:0] == 52'h0);
            o_is_sub = (i_val[62:52] == 11'h000) && (i_val[51:0] != 52'h0);
        end else begin
            o_sign = i_val[31];
            o_is_nan = (i_val[30:23] == 8'hFF) && (i_val[22:0] != 23'h0);
            o_is_snan = o_is_nan && !i_val[22];
            o_is_inf = (i_val[30:23] == 8'hFF) && (i_val[22:0] == 23'h0);
            o_is_sub = (i_val[30:23] == 8'h00) && (i_val[22:0] != 23'h0);
        end
    end
endmodule // fp_nan_classify
`default_nettype wire

// File: design/fp_nan_convert.v
// NaN transformation between single and double formats
`timescale 1ns/1ps
`default_nettype none
`include "fp_policy_defines.vh"
module fp_nan_convert (
    input wire [63:0] i_val,
    input wire [1:0] i_src_fmt,
    input wire [1:0] i_dst_fmt,
    output reg [63:0] o_val
);
    // Leading fraction bits kept, quiet bit forced
    always @* begin
        o_val = 64'h0;
        if (i_src_fmt == `FMT_D && i_dst_fmt == `FMT_S) begin
            // Narrowing drops low fraction bits
            o_val[31:0] = {i_val[63], 8'hFF, 1'b1, i_val[50:29]};
        end else if (i_src_fmt == `FMT_S && i_dst_fmt == `FMT_D) begin
            // Widening pads low fraction bits with zero
            o_val = {i_val[31], 11'h7FF, 1'b1, i_val[21:0], 29'h0};
        end else if (i_dst_fmt == `FMT_D) begin
            o_val = {i_val[63:52], 1'b1, i_val[50:0]};
        end else begin
            o_val[31:0] = {i_val[31:23], 1'b1, i_val[21:0]};
        end
    end
endmodule // fp_nan_convert
`default_nettype wire

// File: bench/fp_policy_monitor.sv
// Assertion checker bound to the exception policy stage
`timescale 1ns/1ps
`default_nettype none
`include "fp_policy_defines.vh"
module fp_policy_monitor #(
    parameter FLUSH_SUPPORT = 0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic [3:0] i_op,
    input wire logic [1:0] i_src_fmt,
    input wire logic [63:0] i_src1,
    input wire logic [63:0] i_src2,
    input wire logic [4:0] i_core_exc,
    input wire logic i_tiny,
    input wire logic i_inexact,
    input wire logic i_rounded_overflow,
    input wire logic [4:0] i_trap_mask,
    input wire logic [63:0] o_dest,
    input wire logic o_dest_we,
    input wire logic [1:0] o_fcc,
    input wire logic [4:0] o_cexc,
    input wire logic [4:0] o_aexc,
    input wire logic o_float_trap,
    input wire logic [2:0] o_trap_type,
    input wire logic o_nonstandard_mode_bit
);
    // Class of an operand as {is NaN, quiet bit}; single sits in the low word
    function automatic logic [1:0] cls(input logic [63:0] v, input logic [1:0] f);
        cls = (f == `FMT_S) ? {&v[30:23] && |v[22:0], v[22]} : {&v[62:52] && |v[51:0], v[51]};
    endfunction
    wire logic [1:0] c1 = cls(i_src1, i_src_fmt);
    wire logic [1:0] c2 = cls(i_src2, i_src_fmt);
    // Tiny result with no competing exception, so only the underflow table decides
    wire logic tiny_op = i_valid && i_op == `OP_ARITH2 && !c1[1] && !c2[1] && i_tiny
        && i_core_exc == {4'h0, i_inexact} && !i_rounded_overflow;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    AST_TRAP_DEST: assert property (o_float_trap |-> !o_dest_we && $stable(o_dest))
        else $error("trap wrote the destination");
    AST_TRAP_FCC: assert property (o_float_trap |-> $stable(o_fcc))
        else $error("trap changed condition codes");
    AST_TRAP_AEXC: assert property (o_float_trap |-> $stable(o_aexc))
        else $error("trap changed accrued flags");
    AST_TRAP_ONEHOT: assert property (
        o_float_trap |-> o_trap_type == `TT_IEEE && $onehot(o_cexc))
        else $error("trap current flags not one-hot");
    AST_SCMP_NAN: assert property (
        i_valid && i_op == `OP_SCMP && (c1[1] || c2[1]) && i_trap_mask == 5'h00
        |=> o_fcc == `FCC_UNORD && o_cexc == 5'h10) else $error("signaling compare on NaN");
    AST_QQ_SECOND: assert property (
        i_valid && i_op == `OP_ARITH2 && c1 == 2'h3 && c2 == 2'h3
        |=> o_dest_we && o_dest == $past(i_src2) && o_cexc == 5'h00) else $error("quiet pair");
    AST_UF_TRAPPED: assert property (
        tiny_op && i_trap_mask == 5'h04 |=> o_float_trap && o_cexc == 5'h04)
        else $error("trapped underflow missed");
    AST_UF_UNTRAPPED: assert property (
        tiny_op && i_trap_mask == 5'h00 |=> !o_float_trap
        && o_cexc == {2'h0, $past(i_inexact), 1'b0, $past(i_inexact)})
        else $error("untrapped underflow flags wrong");
    AST_NS_ZERO: assert property (FLUSH_SUPPORT == 0 |-> !o_nonstandard_mode_bit)
        else $error("mode bit reads one");
endmodule // fp_policy_monitor
bind float_trap_policy fp_policy_monitor #(.FLUSH_SUPPORT(FLUSH_SUPPORT)) i_mon (
    .i_sys_clk, .i_rst_n, .i_valid, .i_op, .i_src_fmt, .i_src1, .i_src2, .i_core_exc, .i_tiny,
    .i_inexact, .i_rounded_overflow, .i_trap_mask, .o_dest, .o_dest_we, .o_fcc, .o_cexc,
    .o_aexc, .o_float_trap, .o_trap_type, .o_nonstandard_mode_bit);
`default_nettype wire

// File: bench/fp_issue_model.sv
// Pipeline-side issuer presenting one operation at a time
`timescale 1ns/1ps
`default_nettype none
module fp_issue_model (
    input wire logic i_sys_clk,
    output logic o_valid,
    output logic [3:0] o_op,
    output logic [3:0] o_fmt,
    output logic [63:0] o_src1,
    output logic [63:0] o_src2,
    output logic [4:0] o_exc,
    output logic [4:0] o_flags,
    output logic [4:0] o_mask,
    output logic o_ns_wr
);
    initial begin
        {o_valid, o_op, o_fmt, o_src1, o_src2, o_exc, o_flags, o_mask, o_ns_wr} = '0;
    end
    // One-cycle request; operands scrambled after so stale values never look valid
    task automatic issue(input logic [3:0] op, input logic [3:0] fmt, input logic [63:0] a,
            input logic [63:0] b, input logic [4:0] exc, input logic [4:0] fl, input logic [4:0] mk);
        @(posedge i_sys_clk);
        o_valid <= 1'b1;
        {o_op, o_fmt, o_src1, o_src2, o_exc, o_flags, o_mask} <= {op, fmt, a, b, exc, fl, mk};
        @(posedge i_sys_clk);
        o_valid <= 1'b0;
        o_src1 <= ~a;
        o_src2 <= ~b;
        #1;
    endtask
    task automatic ns_write();
        @(posedge i_sys_clk);
        o_ns_wr <= 1'b1;
        @(posedge i_sys_clk);
        o_ns_wr <= 1'b0;
        #1;
    endtask
endmodule // fp_issue_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the exception policy stage
`timescale 1ns/1ps
`default_nettype none
`include "fp_policy_defines.vh"
module tb;
    localparam logic [63:0] Q1 = 64'h000000007FC00011;
    localparam logic [63:0] Q2 = 64'h000000007FC00022;
    localparam logic [63:0] S1 = 64'h000000007F800033;
    localparam logic [63:0] S2 = 64'h000000007F800044;
    localparam logic [63:0] NM = 64'h000000003F800000;
    localparam logic [63:0] QB = 64'h0000000000400000;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    int miscompares = 0;
    int comparisons = 0;
    wire logic v, ns_wr, we, trap, ns;
    wire logic [3:0] op, fmt;
    wire logic [63:0] a, b, dest;
    wire logic [4:0] exc, fl, mask, cexc, aexc;
    wire logic [1:0] fcc;
    wire logic [2:0] ttype;
    always #5 i_sys_clk = ~i_sys_clk;
    fp_issue_model m (.i_sys_clk(i_sys_clk), .o_valid(v), .o_op(op), .o_fmt(fmt), .o_src1(a),
        .o_src2(b), .o_exc(exc), .o_flags(fl), .o_mask(mask), .o_ns_wr(ns_wr));
    float_trap_policy #(.FLUSH_SUPPORT(0)) i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_valid(v), .i_op(op), .i_src_fmt(fmt[3:2]), .i_dst_fmt(fmt[1:0]), .i_two_nan_ops(1'b0),
        .i_src1(a), .i_src2(b), .i_core_result(64'h0), .i_core_exc(exc), .i_core_fcc(2'h1),
        .i_tiny(fl[0]), .i_inexact(fl[1]), .i_rounded_overflow(fl[2]), .i_result_sub(fl[3]),
        .i_int_out_of_range(fl[4]), .i_trap_mask(mask), .i_ns_wr(ns_wr), .i_ns_wdata(1'b1),
        .o_dest(dest), .o_dest_we(we), .o_fcc(fcc), .o_cexc(cexc), .o_aexc(aexc),
        .o_float_trap(trap), .o_trap_type(ttype), .o_nonstandard_mode_bit(ns));
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic t_nan_pick();
        logic [63:0] x1 [6] = '{Q1, S1, S1, NM, Q1, NM};
        logic [63:0] x2 [6] = '{Q2, S2, Q2, S2, NM, Q2};
        logic [63:0] ex [6] = '{Q2, S2 | QB, S1 | QB, S2 | QB, Q1, Q2};
        logic [5:0] nv = 6'b001110;
        for (int k = 0; k < 6; k++) begin
            m.issue(`OP_ARITH2, 4'h0, x1[k], x2[k], 5'h00, 5'h00, 5'h00);
            chk({we, dest, cexc}, {1'b1, ex[k], nv[k], 4'h0});
        end
        m.issue(`OP_ARITH1, 4'h0, NM, S2, 5'h00, 5'h00, 5'h00);
        chk({dest, cexc}, {S2 | QB, 5'h10});
        m.issue(`OP_ARITH1, 4'h0, NM, Q1, 5'h00, 5'h00, 5'h00);
        chk({dest, cexc}, {Q1, 5'h00});
    endtask
    task automatic t_default_nan();
        m.issue(`OP_ARITH2, 4'h5, 64'h3FF0000000000000, 64'h0, 5'h10, 5'h00, 5'h00);
        chk(dest, 64'h7FFFFFFFFFFFFFFF);
        m.issue(`OP_ARITH2, 4'h0, NM, 64'h0, 5'h10, 5'h00, 5'h00);
        chk(dest, 64'h000000007FFFFFFF);
    endtask
    // Widening pads low fraction bits with zero, narrowing drops them
    task automatic t_convert();
        logic [63:0] dn = 64'h7FF456789ABCDEF0;
        m.issue(`OP_CONVERT, 4'h1, 64'h0, 64'h7FC00123, 5'h00, 5'h00, 5'h00);
        chk({dest, cexc}, {1'b0, 11'h7FF, 23'h400123, 29'h0, 5'h00});
        m.issue(`OP_CONVERT, 4'h1, 64'h0, 64'h7F800123, 5'h00, 5'h00, 5'h00);
        chk({dest, cexc}, {1'b0, 11'h7FF, 23'h400123, 29'h0, 5'h10});
        m.issue(`OP_CONVERT, 4'h4, 64'h0, dn, 5'h00, 5'h00, 5'h00);
        chk({dest, cexc}, {33'h0, 8'hFF, 1'b1, dn[50:29], 5'h10});
    endtask
    task automatic t_compare();
        logic [3:0] ops [4] = '{`OP_SCMP, `OP_QCMP, `OP_QCMP, `OP_QCMP};
        logic [63:0] x1 [4] = '{NM, Q1, NM, NM};
        logic [63:0] x2 [4] = '{Q2, NM, S2, NM};
        logic [3:0] nv = 4'b0101;
        for (int k = 0; k < 4; k++) begin
            m.issue(ops[k], 4'h0, x1[k], x2[k], 5'h00, 5'h00, 5'h00);
            chk({we, fcc, cexc}, {1'b0, (k == 3) ? 2'h1 : `FCC_UNORD, nv[k], 4'h0});
        end
    endtask
    // Traps must leave destination, codes and accrued flags as they were
    task automatic t_trap_keep();
        logic [1:0] f;
        logic [4:0] ae;
        m.issue(`OP_ARITH2, 4'h0, Q1, Q2, 5'h00, 5'h00, 5'h00);
        f = fcc;
        ae = aexc;
        m.issue(`OP_ARITH2, 4'h0, S1, NM, 5'h00, 5'h00, 5'h10);
        chk({trap, we, dest}, {2'b10, Q2});
        chk({fcc, aexc, cexc, ttype}, {f, ae, 5'h10, `TT_IEEE});
        m.issue(`OP_SCMP, 4'h0, NM, Q2, 5'h00, 5'h00, 5'h10);
        chk({trap, fcc, cexc}, {1'b1, f, 5'h10});
    endtask
    task automatic t_underflow();
        logic [4:0] mk [5] = '{5'h04, 5'h04, 5'h01, 5'h00, 5'h00};
        logic [4:0] fs [5] = '{5'h03, 5'h09, 5'h03, 5'h03, 5'h01};
        logic [4:0] ec [5] = '{5'h04, 5'h04, 5'h01, 5'h05, 5'h00};
        logic [4:0] tp = 5'b00111;
        for (int k = 0; k < 5; k++) begin
            m.issue(`OP_ARITH2, 4'h5, 64'h0010000000000000, 64'h3FF0000000000000,
                {4'h0, fs[k][1]}, fs[k], mk[k]);
            chk({trap, cexc}, {tp[k], ec[k]});
        end
        chk(aexc & 5'h05, 5'h05);
        m.issue(`OP_ARITH2, 4'h5, 64'h0, 64'h0, 5'h00, 5'h04, 5'h00);
        chk(cexc[`EXC_OF], 1'b1);
        m.issue(`OP_ARITH2, 4'h5, 64'h0, 64'h0, 5'h08, 5'h00, 5'h00);
        chk(cexc[`EXC_OF], 1'b0);
    endtask
    task automatic t_toint();
        logic [63:0] x [3] = '{64'h7F800000, 64'hFF800000, 64'h7FC00000};
        for (int k = 0; k < 3; k++) begin
            m.issue(`OP_TOINT, 4'h0, 64'h0, x[k], 5'h00, (k < 2) ? 5'h10 : 5'h00, 5'h00);
            chk({dest, cexc}, {32'h0, (k == 1) ? `INT_NEG_SAT : `INT_POS_SAT, 5'h10});
        end
    endtask
    task automatic t_ns();
        m.ns_write();
        chk(ns, 1'b0);
    endtask
    // Main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_nan_pick();
        t_default_nan();
        t_convert();
        t_compare();
        t_trap_keep();
        t_underflow();
        t_toint();
        t_ns();
        give_verdict();
    end
    // Watchdog, about thirty times the expected run
    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
